// >>> hdl/tx_ctrl_bank.sv
// AXI4-Lite register bank with three transmit channel slices
`include "tx_ctrl_map.svh"

module tx_ctrl_bank (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// write address channel
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address channel
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// system side pins, one bit per channel
	input wire logic [2:0] tx_line_clock_in,
	input wire logic [2:0] tx_positive_data_in,
	input wire logic [2:0] tx_negative_data_in,
	// line side and prbs generator requests
	output logic [2:0] tx_line_pos_out,
	output logic [2:0] tx_line_neg_out,
	output logic [2:0] prbs_error_insert,
	output logic [2:0] buildout_active,
	output logic [2:0] drive_monitor_internal
);
	import tx_ctrl_pkg::*;

	localparam int NCH = `TXC_CHANNELS;

	// register file
	ctrl_s ctrl_q [NCH];
	ctrl_s ctrl_d [NCH];
	logic [7:0] cfg_q, cfg_d;

	// write path state
	wr_state_e wr_q, wr_d;
	logic aw_have_q, aw_have_d;
	logic w_have_q, w_have_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [7:0] wbyte_q, wbyte_d;
	logic wlane0_q, wlane0_d;
	logic awready_q, awready_d;
	logic wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;

	// read path state
	rd_state_e rd_q, rd_d;
	logic arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	// mirrors of channel state
	logic [7:0] err_count [NCH];
	logic [2:0] mon_q, mon_d;

	// channel index of an address, NCH when it is no channel register
	function automatic logic [1:0] chan_of(input logic [7:0] a);
		unique case (a)
			`TXC_OFS_CH0: chan_of = 2'h0;
			`TXC_OFS_CH1: chan_of = 2'h1;
			`TXC_OFS_CH2: chan_of = 2'h2;
			default: chan_of = 2'h3;
		endcase
	endfunction : chan_of

	// true for every address the bank answers with OKAY
	function automatic logic mapped(input logic [7:0] a);
		mapped = (chan_of(a) != 2'h3) || (a == `TXC_OFS_CONFIG)
			|| (a == `TXC_OFS_STATUS);
	endfunction : mapped

	// byte view of one channel's control fields, unused bits read zero
	function automatic logic [7:0] ctrl_byte(input ctrl_s c);
		ctrl_byte = 8'h00;
		ctrl_byte[`TXC_BIT_DRV_MON] = c.drive_monitor;
		ctrl_byte[`TXC_BIT_INS_ERR] = c.insert_error;
		ctrl_byte[`TXC_BIT_ALL_ONES] = c.send_all_ones;
		ctrl_byte[`TXC_BIT_EDGE_SEL] = c.tx_clock_edge_select;
		ctrl_byte[`TXC_BIT_BUILDOUT] = c.line_buildout_select;
	endfunction : ctrl_byte

	// write address and data are caught in either order, then applied
	always_comb begin
		wr_d = wr_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wbyte_d = wbyte_q;
		wlane0_d = wlane0_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (s_axi_awvalid && awready_q) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_have_d = 1'b1;
			wbyte_d = s_axi_wdata[7:0];
			wlane0_d = s_axi_wstrb[0];
		end
		unique case (wr_q)
			WR_IDLE: begin
				if (aw_have_q && w_have_q) begin
					bvalid_d = 1'b1;
					bresp_d = mapped(awaddr_q) ? `TXC_RESP_OKAY
						: `TXC_RESP_SLVERR;
					aw_have_d = 1'b0;
					w_have_d = 1'b0;
					wr_d = WR_RESP;
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					bvalid_d = 1'b0;
					wr_d = WR_IDLE;
				end
			end
		endcase
		// one write under way at a time: hold off until the answer is taken
		awready_d = !aw_have_d && (wr_d == WR_IDLE);
		wready_d = !w_have_d && (wr_d == WR_IDLE);
	end

	// register updates; only byte lane 0 carries writable bits
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			ctrl_d[i] = ctrl_q[i];
		end
		cfg_d = cfg_q;
		if (wr_q == WR_IDLE && aw_have_q && w_have_q && wlane0_q) begin
			if (chan_of(awaddr_q) != 2'h3) begin
				// each channel owns its own fields
				ctrl_d[chan_of(awaddr_q)] = '{
					drive_monitor: wbyte_q[`TXC_BIT_DRV_MON],
					insert_error: wbyte_q[`TXC_BIT_INS_ERR],
					send_all_ones: wbyte_q[`TXC_BIT_ALL_ONES],
					tx_clock_edge_select: wbyte_q[`TXC_BIT_EDGE_SEL],
					line_buildout_select: wbyte_q[`TXC_BIT_BUILDOUT]};
			end else if (awaddr_q == `TXC_OFS_CONFIG) begin
				cfg_d = wbyte_q & `TXC_CFG_WMASK;
			end
		end
	end

	// read path answers one cycle after the address is taken
	always_comb begin
		rd_d = rd_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		unique case (rd_q)
			RD_IDLE: begin
				if (s_axi_arvalid && arready_q) begin
					rvalid_d = 1'b1;
					rresp_d = mapped(s_axi_araddr) ? `TXC_RESP_OKAY
						: `TXC_RESP_SLVERR;
					rdata_d = 32'h0000_0000;
					if (chan_of(s_axi_araddr) != 2'h3) begin
						rdata_d[7:0] = ctrl_byte(ctrl_q[chan_of(s_axi_araddr)]);
					end else if (s_axi_araddr == `TXC_OFS_CONFIG) begin
						rdata_d[7:0] = cfg_q;
					end else if (s_axi_araddr == `TXC_OFS_STATUS) begin
						// live counts of single-bit errors handed to each generator
						rdata_d[23:0] = {err_count[2], err_count[1], err_count[0]};
					end
					rd_d = RD_DATA;
				end
			end
			RD_DATA: begin
				if (s_axi_rready) begin
					rvalid_d = 1'b0;
					rd_d = RD_IDLE;
				end
			end
		endcase
		arready_d = (rd_d == RD_IDLE);
	end

	// drive monitor select is only stored and passed out
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			mon_d[i] = ctrl_q[i].drive_monitor;
		end
	end

	// bus and register file state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NCH; i++) begin
				// byte-wide reset value cut to the five stored fields
				ctrl_q[i] <= 5'(`TXC_CTRL_RESET);
			end
			cfg_q <= `TXC_CFG_RESET;
			wr_q <= WR_IDLE;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wbyte_q <= 8'h00;
			wlane0_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `TXC_RESP_OKAY;
			rd_q <= RD_IDLE;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `TXC_RESP_OKAY;
			mon_q <= 3'h0;
		end else if (ce) begin
			for (int i = 0; i < NCH; i++) begin
				ctrl_q[i] <= ctrl_d[i];
			end
			cfg_q <= cfg_d;
			wr_q <= wr_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wbyte_q <= wbyte_d;
			wlane0_q <= wlane0_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rd_q <= rd_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			mon_q <= mon_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign drive_monitor_internal = mon_q;

	// per-channel pin synchronisers and datapaths
	generate
		for (genvar c = 0; c < NCH; c++) begin : g_ch
			pins_s pins;
			rail_s line;

			// clock and rails share one filter so they stay aligned
			pin_sync #(
				.W(`TXC_SYNC_BITS)
			) u_sync (
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.async_in({tx_line_clock_in[c], tx_positive_data_in[c],
					tx_negative_data_in[c]}),
				.stable_q(pins)
			);

			tx_channel u_chan (
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.ctrl(ctrl_q[c]),
				.prbs_enable(cfg_q[`TXC_CFG_PRBS_LSB + c]),
				.e3_mode(cfg_q[`TXC_CFG_E3_LSB + c]),
				.pins(pins),
				.line_q(line),
				.error_insert_q(prbs_error_insert[c]),
				.buildout_active_q(buildout_active[c]),
				.error_count_q(err_count[c])
			);

			assign tx_line_pos_out[c] = line.pos;
			assign tx_line_neg_out[c] = line.neg;
		end
	endgenerate

endmodule : tx_ctrl_bank

// >>> hdl/tx_ctrl_map.svh
// offsets, field positions, reset values and counts of the transmit control bank
`ifndef TX_CTRL_MAP_SVH
`define TX_CTRL_MAP_SVH

// byte addresses of the per-channel transmit control registers
`define TXC_OFS_CH0 8'h04
`define TXC_OFS_CH1 8'h0C
`define TXC_OFS_CH2 8'h14
// channel configuration (prbs enables, rate mode) and error count status
`define TXC_OFS_CONFIG 8'h18
`define TXC_OFS_STATUS 8'h1C

// fields of tx_channel_control
`define TXC_BIT_BUILDOUT 0
`define TXC_BIT_EDGE_SEL 1
`define TXC_BIT_ALL_ONES 2
`define TXC_BIT_INS_ERR 4
`define TXC_BIT_DRV_MON 5
`define TXC_CTRL_RESET 8'h00
// writable bits 5,4,2,1,0; bits 7,6,3 read zero
`define TXC_CTRL_WMASK 8'h37

// fields of the configuration register
`define TXC_CFG_PRBS_LSB 0
`define TXC_CFG_E3_LSB 4
`define TXC_CFG_RESET 8'h00
`define TXC_CFG_WMASK 8'h77

// bus answers
`define TXC_RESP_OKAY 2'h0
`define TXC_RESP_SLVERR 2'h2

`define TXC_CHANNELS 3
`define TXC_SYNC_BITS 3

`endif

// >>> hdl/tx_ctrl_pkg.sv
// types shared by the transmit control bank and its channel slices
package tx_ctrl_pkg;

	// one channel's writable control fields
	typedef struct packed {
		logic drive_monitor;
		logic insert_error;
		logic send_all_ones;
		logic tx_clock_edge_select;
		logic line_buildout_select;
	} ctrl_s;

	// one dual-rail pair of data
	typedef struct packed {
		logic pos;
		logic neg;
	} rail_s;

	// one channel's pin group after synchronising
	typedef struct packed {
		logic clk;
		rail_s data;
	} pins_s;

	typedef enum logic [0:0] {
		WR_IDLE,
		WR_RESP
	} wr_state_e;

	typedef enum logic [0:0] {
		RD_IDLE,
		RD_DATA
	} rd_state_e;

endpackage : tx_ctrl_pkg

// >>> hdl/pin_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
module pin_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] stable_q
);
	logic [W-1:0] s1_q, s2_q, s3_q, stable_d;

	// only the second and third stages feed the filter, the first flop never does
	always_comb begin
		for (int i = 0; i < W; i++) begin
			stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
		end
	end

	// stages and filter freeze with the clock enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			stable_q <= '0;
		end else if (ce) begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			stable_q <= stable_d;
		end
	end

endmodule : pin_sync

// >>> hdl/tx_channel.sv
// one transmit channel: edge-selected sampling, all-ones override, error pulse
`include "tx_ctrl_map.svh"
module tx_channel (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire tx_ctrl_pkg::ctrl_s ctrl,
	input wire logic prbs_enable,
	input wire logic e3_mode,
	input wire tx_ctrl_pkg::pins_s pins,
	output tx_ctrl_pkg::rail_s line_q,
	output logic error_insert_q,
	output logic buildout_active_q,
	output logic [7:0] error_count_q
);
	import tx_ctrl_pkg::*;

	logic clk_prev_q, clk_prev_d;
	logic ins_prev_q, ins_prev_d;
	logic mark_q, mark_d;
	rail_s line_d;
	logic error_insert_d, buildout_active_d, take;
	logic [7:0] error_count_d;

	// next state of the channel datapath
	always_comb begin
		clk_prev_d = pins.clk;
		// rising edge when selected, falling edge otherwise
		take = ctrl.tx_clock_edge_select ? (pins.clk & ~clk_prev_q)
			: (~pins.clk & clk_prev_q);
		line_d = line_q;
		mark_d = mark_q;
		if (take) begin
			if (ctrl.send_all_ones) begin
				// marks alternate polarity so the line stays balanced
				line_d.pos = ~mark_q;
				line_d.neg = mark_q;
				mark_d = ~mark_q;
			end else begin
				line_d = pins.data;
			end
		end
		// compare against the last registered value, ignore when off
		ins_prev_d = ctrl.insert_error;
		error_insert_d = ctrl.insert_error & ~ins_prev_q
			& prbs_enable;
		error_count_d = error_count_q + {7'h00, error_insert_d};
		// shaping only follows the field outside E3 operation
		buildout_active_d = ctrl.line_buildout_select & ~e3_mode;
	end

	// registers of the channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_prev_q <= 1'b0;
			ins_prev_q <= 1'b0;
			mark_q <= 1'b0;
			line_q <= '0;
			error_insert_q <= 1'b0;
			buildout_active_q <= 1'b0;
			error_count_q <= 8'h00;
		end else if (ce) begin
			clk_prev_q <= clk_prev_d;
			ins_prev_q <= ins_prev_d;
			mark_q <= mark_d;
			line_q <= line_d;
			error_insert_q <= error_insert_d;
			buildout_active_q <= buildout_active_d;
			error_count_q <= error_count_d;
		end
	end

endmodule : tx_channel

// >>> verification/tx_ctrl_bank_asserts.sv
// port assertions for the transmit control bank
module tx_ctrl_bank_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] tx_line_clock_in,
	input wire logic [2:0] tx_line_pos_out,
	input wire logic [2:0] prbs_error_insert
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// error requests last one cycle and only follow a write answer
	pulse_once_a: assert property (
		!(|(prbs_error_insert & $past(prbs_error_insert))))
		else $error("error pulse too long");
	pulse_cause_a: assert property (
		|(prbs_error_insert & ~$past(prbs_error_insert)) |->
		$past(s_axi_bvalid))
		else $error("error pulse without write");
	// write answer waits for both channels, then two edges
	resp_after_both_a: assert property (
		$rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
		else $error("write answer too early");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	// read data one edge after the address, held until taken
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	read_upper_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
		else $error("read upper byte set");
	// rails move only shortly after a line clock edge
	line_moves_a: assert property (
		!$stable(tx_line_pos_out) |->
		tx_line_clock_in != $past(tx_line_clock_in, 8))
		else $error("line moved without clock edge");
	// main scenarios reached
	cover property (|prbs_error_insert);
	cover property (s_axi_rvalid && !s_axi_rready);
	cover property ($rose(s_axi_bvalid));
endmodule : tx_ctrl_bank_asserts

bind tx_ctrl_bank tx_ctrl_bank_asserts chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .tx_line_clock_in, .tx_line_pos_out, .prbs_error_insert);

// >>> verification/tx_source_model.sv
// system side source: line clock and dual-rail data, three channels
module tx_source_model (
	input wire logic aclk,
	output logic [2:0] tx_line_clock_in,
	output logic [2:0] tx_positive_data_in,
	output logic [2:0] tx_negative_data_in,
	output logic [4:0] phase
);
	timeunit 1ns;
	timeprecision 1ps;
	initial phase = 5'h00;
	// bit period of 24 aclk, clock rises at phase 0, falls at 12
	always @(posedge aclk) begin
		phase <= (phase == 5'h17) ? 5'h00 : phase + 5'h01;
	end
	// rails move midway, so each edge sees other data, settled
	assign tx_line_clock_in = {3{phase < 5'h0C}};
	assign tx_positive_data_in = {3{phase >= 5'h06 && phase < 5'h12}};
	assign tx_negative_data_in = ~tx_positive_data_in;
endmodule : tx_source_model

// >>> verification/tb_tx_ctrl_bank.sv
// self-checking bench for the transmit control bank
module tb_tx_ctrl_bank;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, ce;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [2:0] tx_line_clock_in, tx_positive_data_in, tx_negative_data_in;
	logic [2:0] tx_line_pos_out, tx_line_neg_out, prbs_error_insert;
	logic [2:0] buildout_active, drive_monitor_internal, p;
	logic [4:0] phase;
	int mismatches, total_checks, pulses;

	tx_ctrl_bank uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .tx_line_clock_in, .tx_positive_data_in,
		.tx_negative_data_in, .tx_line_pos_out, .tx_line_neg_out,
		.prbs_error_insert, .buildout_active, .drive_monitor_internal);
	tx_source_model src (.aclk, .tx_line_clock_in, .tx_positive_data_in,
		.tx_negative_data_in, .phase);

	// free running system clock
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// count channel 0 request pulses
	always @(posedge aclk) pulses <= pulses + int'(prbs_error_insert[0]);

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	// one write; bready stays high so no pulse on it is needed
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		check(s_axi_bresp, r);
	endtask : wr

	// one read; rready held back a cycle so held data is exercised
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, d);
		check(s_axi_rresp, r);
	endtask : rd

	// wait for bit starts, where both kinds of edge have settled
	task automatic align(input int n);
		repeat (n) do @(posedge aclk); while (phase != 5'h00);
	endtask : align

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (5000) @(posedge aclk);
		mismatches++;
		test_done();
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awprot, s_axi_arprot, s_axi_rready} = 7'h00;
		{ce, s_axi_bready, s_axi_wstrb} = 6'h3F;
		pulses = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// registers come up clear
		rd(8'h04, 32'h0, 2'h0);
		rd(8'h0C, 32'h0, 2'h0);
		rd(8'h14, 32'h0, 2'h0);
		rd(8'h18, 32'h0, 2'h0);
		// unused bits read zero; insert dropped while prbs is off
		wr(8'h04, 32'hFF, 2'h0);
		rd(8'h04, 32'h37, 2'h0);
		check(buildout_active, 3'h1);
		check(drive_monitor_internal, 3'h1);
		// E3 mode overrides buildout
		wr(8'h18, 32'h10, 2'h0);
		rd(8'h18, 32'h10, 2'h0);
		check(buildout_active, 3'h0);
		// unmapped places refused
		wr(8'h00, 32'h1, 2'h2);
		rd(8'h08, 32'h0, 2'h2);
		// plain data, then rising edge chosen on channel 1 alone
		wr(8'h04, 32'h0, 2'h0);
		align(2);
		check(tx_line_pos_out, 3'h7);
		check(tx_line_neg_out, 3'h0);
		wr(8'h0C, 32'h2, 2'h0);
		align(2);
		check(tx_line_pos_out, 3'h5);
		check(tx_line_neg_out, 3'h2);
		// all-ones on channel 0: marks alternate each bit
		wr(8'h04, 32'h4, 2'h0);
		align(2);
		p = tx_line_pos_out;
		check(tx_line_pos_out ^ tx_line_neg_out, 3'h7);
		align(1);
		check(tx_line_pos_out ^ p, 3'h1);
		// prbs on: one pulse per fresh 0-to-1 write
		wr(8'h18, 32'hFF, 2'h0);
		rd(8'h18, 32'h77, 2'h0);
		wr(8'h04, 32'h10, 2'h0);
		wr(8'h04, 32'h10, 2'h0);
		wr(8'h04, 32'h0, 2'h0);
		wr(8'h04, 32'h10, 2'h0);
		rd(8'h1C, 32'h2, 2'h0);
		check(pulses, 32'h2);
		// status ignores writes
		wr(8'h1C, 32'hFF, 2'h0);
		rd(8'h1C, 32'h2, 2'h0);
		test_done();
	end
endmodule : tb_tx_ctrl_bank
